// ---- shared/lcdcp_cfg.svh ----
// timing, opcodes, fields and offsets of the command port
`ifndef LCDCP_CFG_SVH
`define LCDCP_CFG_SVH
// ****************************************************************
// bus timing (ns)
// ****************************************************************
`define LCDCP_CLK_NS 20
`define LCDCP_T_AS_NS 80
`define LCDCP_T_WRW_NS 200
`define LCDCP_T_RDW_NS 500
`define LCDCP_T_DH_NS 80
`define LCDCP_T_CYC_NS 900
`define LCDCP_CYC(ns) (((ns) + `LCDCP_CLK_NS - 1) / `LCDCP_CLK_NS)
// ****************************************************************
// command codes (upper data nibble) and fields
// ****************************************************************
`define LCDCP_OP_COL 4'h0
`define LCDCP_OP_ROW_LO 4'h2
`define LCDCP_OP_ROW_HI 4'h3
`define LCDCP_OP_LAST 4'h9
`define LCDCP_OP_DCTL1 4'h8
`define LCDCP_OP_DCTL2 4'h9
`define LCDCP_REF_BIT 0
`define LCDCP_COL_RST 4'h0
`define LCDCP_COL_MAX 4'hF
`define LCDCP_BUS_IDLE 8'hFF
// ****************************************************************
// host registers on axi4-lite
// ****************************************************************
`define LCDCP_OFS_CMD 4'h0
`define LCDCP_OFS_STATUS 4'h4
`define LCDCP_OFS_RDATA 4'h8
`define LCDCP_CMD_RS_BIT 8
`define LCDCP_CMD_RD_BIT 9
`define LCDCP_CMD_EXT_BIT 10
`define LCDCP_RESP_OKAY 2'h0
`define LCDCP_RESP_SLVERR 2'h2
`endif

// ---- shared/lcdcp_pkg.sv ----
// types and command classification shared by both ends
`include "lcdcp_cfg.svh"
package lcdcp_pkg;
  typedef logic [7:0]  lcdcp_byte_t;
  typedef logic [31:0] lcdcp_word_t;
  typedef struct packed {
    logic        ext;
    logic        rd;
    logic        rs;
    lcdcp_byte_t data;
  } lcdcp_cmd_s;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_PULSE = 5'h04,
    ST_HOLD  = 5'h08,
    ST_GAP   = 5'h10
  } lcdcp_hst_e;
  function automatic logic lcdcp_is_reg_wr(input lcdcp_cmd_s c);
    return c.rs && !c.rd && !c.ext;
  endfunction : lcdcp_is_reg_wr
  function automatic logic lcdcp_code_ok(input lcdcp_cmd_s c);
    if (!c.rs || c.rd) return 1'b1;
    if (c.ext) return c.data[7:4] == `LCDCP_OP_DCTL1;
    return c.data[7:4] != 4'h1 && c.data[7:4] <= `LCDCP_OP_LAST;
  endfunction : lcdcp_code_ok
endpackage : lcdcp_pkg

// ---- shared/lcdcp_if.sv ----
// parallel 80-family bus between host end and device end
`timescale 1ns/100ps
`include "lcdcp_cfg.svh"
interface lcdcp_if;
  logic        chip_select_n;
  logic        cmd_data_select;
  logic        ext_bank_select;
  logic        wr_n;
  logic        rd_n;
  logic [7:0]  host_db;
  logic        host_db_oe;
  logic [7:0]  dev_db;
  logic        dev_db_oe;
  logic [7:0]  db;
  // resolved bus, pulled high when undriven
  assign db = host_db_oe ? host_db : (dev_db_oe ? dev_db : `LCDCP_BUS_IDLE);
  modport host (
    output chip_select_n, cmd_data_select, ext_bank_select, wr_n, rd_n,
    output host_db, host_db_oe,
    input  db
  );
  modport dev (
    input  chip_select_n, cmd_data_select, ext_bank_select, wr_n, rd_n,
    input  db,
    output dev_db, dev_db_oe
  );
endinterface : lcdcp_if

// ---- logic/lcdcp_fifo.sv ----
// command fifo with valid and ready on both sides
`timescale 1ns/100ps
module lcdcp_fifo #(
  parameter int W = 11,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  if (D < 2 || W < 1) begin : g_chk
    $error("lcdcp_fifo: depth below 2 or zero width");
  end
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;
  assign in_ready  = cnt_ff != (AW + 1)'(D);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + AW'(1);
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : lcdcp_fifo

// ---- logic/lcdcp_device.sv ----
// device end: transfer decoder, column address register and display ram
`timescale 1ns/100ps
`include "lcdcp_cfg.svh"
// ****************************************************************
// Notes on behaviour
// (R1) transfers count only while chip select low
// (R2) selector 0 ram data, 1 register access
// (R3) host never issues undefined command codes
// (R4) data write stores byte at column, row
// (R5) data read returns byte at column, row
// (R6) first read after address set is dummy
// (R7) opcode 0 write loads column address nibble
// (R8) column resets zero, read at address 0H
// (R9) host writes column values 00H-0FH only
// (R10) reversal off: column used unchanged
// (R11) reversal on: ram column is 0FH minus value
// (R12) reversal is control2 bit D0, reset 0
// (R13) row address written low nibble first
// ****************************************************************
module lcdcp_device #(
  parameter int COL_W = 4,
  parameter int ROW_W = 7
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // lcd bus from the host
  lcdcp_if.dev                        lcd,
  // display scan read port
  input  wire logic [COL_W+ROW_W-1:0] scan_addr,
  output lcdcp_pkg::lcdcp_byte_t      scan_data,
  // address and mapping state
  output logic [COL_W-1:0]            column_address_bits,
  output logic [ROW_W-1:0]            row_address_bits,
  output logic                        col_reversed
);
  import lcdcp_pkg::*;

  localparam int AW    = COL_W + ROW_W;
  localparam int DEPTH = 1 << AW;

  // the opcode layout puts the column in the low nibble
  if (COL_W != 4 || ROW_W < 4 || ROW_W > 7) begin : g_chk
    $error("lcdcp_device: unsupported address widths");
  end

  // ****************************************************************
  // sampled bus
  // ****************************************************************
  logic        cs_n_ff;
  logic        rs_ff;
  logic        ext_ff;
  logic        wr_n_ff;
  logic        rd_n_ff;
  lcdcp_byte_t db_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_n_ff <= 1'b1;
      rs_ff   <= 1'b0;
      ext_ff  <= 1'b0;
      wr_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      db_ff   <= 8'h00;
    end else begin
      cs_n_ff <= lcd.chip_select_n;
      rs_ff   <= lcd.cmd_data_select;
      ext_ff  <= lcd.ext_bank_select;
      wr_n_ff <= lcd.wr_n;
      rd_n_ff <= lcd.rd_n;
      db_ff   <= lcd.db;
    end
  end

  // ****************************************************************
  // transfer events
  // ****************************************************************
  // writes act on the rising strobe, using the byte held during it
  logic       wr_evt;
  logic       rd_start;
  logic       rd_end;
  logic       ram_wr;
  logic       reg_wr;
  logic [3:0] op;

  assign wr_evt   = !wr_n_ff && lcd.wr_n && !cs_n_ff; // (R1)
  assign rd_start = rd_n_ff && !lcd.rd_n && !lcd.chip_select_n; // (R1)
  assign rd_end   = !rd_n_ff && lcd.rd_n && !cs_n_ff; // (R1)
  assign ram_wr   = wr_evt && !rs_ff; // (R2)
  assign reg_wr   = wr_evt && rs_ff && !ext_ff; // (R2)
  assign op       = db_ff[7:4];

  // ****************************************************************
  // address registers
  // ****************************************************************
  logic [COL_W-1:0] col_ff;
  logic [ROW_W-1:0] row_ff;
  logic             ref_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_ff <= `LCDCP_COL_RST; // (R8)
    end else if (reg_wr && op == `LCDCP_OP_COL) begin
      col_ff <= db_ff[3:0]; // (R7)
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_ff <= '0;
    end else if (reg_wr && op == `LCDCP_OP_ROW_LO) begin
      row_ff[3:0] <= db_ff[3:0];
    end else if (reg_wr && op == `LCDCP_OP_ROW_HI) begin
      row_ff[ROW_W-1:4] <= db_ff[ROW_W-5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ff <= 1'b0; // (R12)
    end else if (reg_wr && op == `LCDCP_OP_DCTL2) begin
      ref_ff <= db_ff[`LCDCP_REF_BIT]; // (R12)
    end
  end

  // ****************************************************************
  // display ram
  // ****************************************************************
  logic [COL_W-1:0] col_map;
  logic [AW-1:0]    ram_addr;
  lcdcp_byte_t      mem [0:DEPTH-1];
  lcdcp_byte_t      rd_latch_ff;
  lcdcp_byte_t      scan_ff;

  // reversal mirrors segments; the host view is unchanged
  assign col_map  = ref_ff ? (`LCDCP_COL_MAX - col_ff) : col_ff; // (R10) (R11)
  assign ram_addr = {row_ff, col_map};

  always_ff @(posedge aclk) begin
    if (ram_wr) begin
      mem[ram_addr] <= db_ff; // (R4)
    end
  end

  // latch reloads only as a ram read ends: the read after an address change is stale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_latch_ff <= 8'h00;
    end else if (rd_end && !rs_ff) begin
      rd_latch_ff <= mem[ram_addr]; // (R5) (R6)
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_ff <= 8'h00;
    end else begin
      scan_ff <= mem[scan_addr];
    end
  end

  // ****************************************************************
  // read data drive
  // ****************************************************************
  lcdcp_byte_t dout_ff;
  logic        doe_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      doe_ff  <= 1'b0;
      dout_ff <= 8'h00;
    end else if (rd_start) begin
      doe_ff <= 1'b1;
      if (lcd.cmd_data_select) begin
        dout_ff <= {4'h0, col_ff}; // (R2) (R8)
      end else begin
        dout_ff <= rd_latch_ff; // (R5)
      end
    end else if (lcd.rd_n || lcd.chip_select_n) begin
      doe_ff <= 1'b0; // (R1)
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign lcd.dev_db          = dout_ff;
  assign lcd.dev_db_oe       = doe_ff;
  assign scan_data           = scan_ff;
  assign column_address_bits = col_ff;
  assign row_address_bits    = row_ff;
  assign col_reversed        = ref_ff;

endmodule : lcdcp_device

// ---- logic/lcdcp_host.sv ----
// host end: axi4-lite command registers, command fifo and bus cycle engine
`timescale 1ns/100ps
`include "lcdcp_cfg.svh"
module lcdcp_host #(
  parameter int T_AS  = `LCDCP_CYC(`LCDCP_T_AS_NS),
  parameter int T_WRW = `LCDCP_CYC(`LCDCP_T_WRW_NS),
  parameter int T_RDW = `LCDCP_CYC(`LCDCP_T_RDW_NS),
  parameter int T_DH  = `LCDCP_CYC(`LCDCP_T_DH_NS),
  parameter int T_CYC = `LCDCP_CYC(`LCDCP_T_CYC_NS),
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write
  input  wire logic [3:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire lcdcp_pkg::lcdcp_word_t s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output lcdcp_pkg::lcdcp_word_t      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // lcd bus
  lcdcp_if.host                       lcd
);
  import lcdcp_pkg::*;
  localparam int GAP_W = (T_CYC - T_AS - T_WRW - T_DH > 1) ? T_CYC - T_AS - T_WRW - T_DH : 1;
  localparam int GAP_R = (T_CYC - T_AS - T_RDW - T_DH > 1) ? T_CYC - T_AS - T_RDW - T_DH : 1;
  if (T_AS < 1 || T_WRW < 1 || T_RDW < 3 || T_DH < 1 || T_CYC > 255 || T_RDW > 255
      || T_WRW > 255) begin : g_chk
    $error("lcdcp_host: timing counts out of range");
  end
  logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [3:0]  awaddr_ff, wstrb_ff;
  lcdcp_word_t wdata_ff, rdata_ff;
  logic aw_hs, w_hs, ar_hs, is_cmd, mapped, cmd_ok, wr_do, push, f_ready, f_valid, take;
  logic row_lo_ff, dummy_ff, rsp_valid_ff, cap;
  lcdcp_byte_t rsp_data_ff;
  lcdcp_cmd_s  cmd, f_data;
  lcdcp_hst_e  st_ff;
  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign aw_hs  = s_axi_awvalid && awready_ff;
  assign w_hs   = s_axi_wvalid && wready_ff;
  assign ar_hs  = s_axi_arvalid && arready_ff;
  assign cmd    = '{ext: wdata_ff[`LCDCP_CMD_EXT_BIT], rd: wdata_ff[`LCDCP_CMD_RD_BIT],
                    rs: wdata_ff[`LCDCP_CMD_RS_BIT], data: wdata_ff[7:0]};
  assign is_cmd = awaddr_ff == `LCDCP_OFS_CMD;
  assign mapped = is_cmd || awaddr_ff == `LCDCP_OFS_STATUS || awaddr_ff == `LCDCP_OFS_RDATA;
  assign cmd_ok = lcdcp_code_ok(cmd) && !(lcdcp_is_reg_wr(cmd) // (R3) (R9)
                  && cmd.data[7:4] == `LCDCP_OP_ROW_HI && !row_lo_ff); // (R13)
  // a full fifo holds the write response back, which stalls the master
  assign wr_do  = aw_got_ff && w_got_ff && !bvalid_ff && (!is_cmd || !cmd_ok || f_ready);
  assign push   = wr_do && is_cmd && cmd_ok && wstrb_ff[1:0] == 2'h3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready_ff, wready_ff, aw_got_ff, w_got_ff, bvalid_ff} <= 5'h00;
      {bresp_ff, awaddr_ff, wstrb_ff, wdata_ff} <= '0;
    end else begin
      awready_ff <= !(aw_got_ff || aw_hs) && !bvalid_ff;
      wready_ff  <= !(w_got_ff || w_hs) && !bvalid_ff;
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_do) aw_got_ff <= 1'b0;
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_do) w_got_ff <= 1'b0;
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (!mapped || (is_cmd && !cmd_ok)) ? `LCDCP_RESP_SLVERR : `LCDCP_RESP_OKAY;
      end else if (s_axi_bready) bvalid_ff <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {arready_ff, rvalid_ff, rresp_ff, rdata_ff} <= '0;
    end else begin
      arready_ff <= !ar_hs && !rvalid_ff;
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= `LCDCP_RESP_OKAY;
        case (s_axi_araddr)
          `LCDCP_OFS_CMD:    rdata_ff <= 32'h0000_0000;
          `LCDCP_OFS_STATUS: rdata_ff <= {29'h0000_0000, rsp_valid_ff, !f_ready,
                                          f_valid || st_ff != ST_IDLE};
          `LCDCP_OFS_RDATA:  rdata_ff <= {24'h00_0000, rsp_data_ff};
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `LCDCP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) rvalid_ff <= 1'b0;
    end
  end
  // ****************************************************************
  // command fifo and sequencing flags
  // ****************************************************************
  lcdcp_fifo #(.W($bits(lcdcp_cmd_s)), .D(DEPTH)) u_fifo (
    .aclk(aclk), .aresetn(aresetn), .in_valid(push), .in_ready(f_ready), .in_data(cmd),
    .out_valid(f_valid), .out_ready(take), .out_data(f_data));
  always_ff @(posedge aclk) begin
    if (!aresetn) row_lo_ff <= 1'b0;
    else if (push && lcdcp_is_reg_wr(cmd) && cmd.data[7:4] == `LCDCP_OP_ROW_LO) row_lo_ff <= 1'b1;
    else if (push && lcdcp_is_reg_wr(cmd) && cmd.data[7:4] == `LCDCP_OP_ROW_HI) row_lo_ff <= 1'b0;
  end
  // an address change makes the next ram read a dummy
  always_ff @(posedge aclk) begin
    if (!aresetn) dummy_ff <= 1'b1;
    else if (take && lcdcp_is_reg_wr(f_data) && f_data.data[7:4] <= `LCDCP_OP_ROW_HI) dummy_ff <= 1'b1; // (R6)
    else if (take && f_data.rd && !f_data.rs) dummy_ff <= 1'b0; // (R6)
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else if (cap) begin
      rsp_valid_ff <= 1'b1;
      rsp_data_ff  <= lcd.db;
    end else if (ar_hs && s_axi_araddr == `LCDCP_OFS_RDATA) rsp_valid_ff <= 1'b0;
  end
  // ****************************************************************
  // bus cycle engine
  // ****************************************************************
  lcdcp_cmd_s cur_ff;
  logic [7:0] cnt_ff;
  logic cs_n_ff, rs_ff, ext_ff, wr_n_ff, rd_n_ff, oe_ff, skip_ff;
  lcdcp_byte_t db_ff;
  assign take = f_valid && st_ff == ST_IDLE;
  assign cap  = st_ff == ST_PULSE && cnt_ff == 8'h00 && cur_ff.rd && !skip_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
      {cnt_ff, cur_ff, skip_ff, rs_ff, ext_ff, oe_ff, db_ff} <= '0;
      {cs_n_ff, wr_n_ff, rd_n_ff} <= 3'h7;
    end else begin
      unique case (st_ff)
        ST_IDLE: if (take) begin
          cur_ff  <= f_data;
          skip_ff <= f_data.rd && !f_data.rs && dummy_ff; // (R6)
          cs_n_ff <= 1'b0; // (R1)
          rs_ff   <= f_data.rs;
          ext_ff  <= f_data.ext;
          db_ff   <= f_data.data;
          oe_ff   <= !f_data.rd;
          cnt_ff  <= 8'(T_AS - 1);
          st_ff   <= ST_SETUP;
        end
        ST_SETUP: if (cnt_ff == 8'h00) begin
          wr_n_ff <= cur_ff.rd;
          rd_n_ff <= !cur_ff.rd;
          cnt_ff  <= cur_ff.rd ? 8'(T_RDW - 1) : 8'(T_WRW - 1);
          st_ff   <= ST_PULSE;
        end else cnt_ff <= cnt_ff - 8'h01;
        ST_PULSE: if (cnt_ff == 8'h00) begin
          {wr_n_ff, rd_n_ff} <= 2'h3;
          cnt_ff <= 8'(T_DH - 1);
          st_ff  <= ST_HOLD;
        end else cnt_ff <= cnt_ff - 8'h01;
        ST_HOLD: if (cnt_ff == 8'h00) begin
          cs_n_ff <= 1'b1;
          oe_ff   <= 1'b0;
          cnt_ff  <= cur_ff.rd ? 8'(GAP_R - 1) : 8'(GAP_W - 1);
          st_ff   <= ST_GAP;
        end else cnt_ff <= cnt_ff - 8'h01;
        ST_GAP: if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
        else if (skip_ff) begin
          skip_ff <= 1'b0; // (R6)
          cs_n_ff <= 1'b0;
          cnt_ff  <= 8'(T_AS - 1);
          st_ff   <= ST_SETUP;
        end else st_ff <= ST_IDLE;
      endcase
    end
  end
  assign lcd.chip_select_n   = cs_n_ff;
  assign lcd.cmd_data_select = rs_ff; // (R2)
  assign lcd.ext_bank_select = ext_ff;
  assign lcd.wr_n            = wr_n_ff;
  assign lcd.rd_n            = rd_n_ff;
  assign lcd.host_db         = db_ff;
  assign lcd.host_db_oe      = oe_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
endmodule : lcdcp_host

// ---- dv/lcdcp_wire_asserts.sv ----
// concurrent checks on the bus between the two ends
`timescale 1ns/100ps
module lcdcp_wire_asserts #(
  parameter int T_WRW = 2,
  parameter int T_RDW = 4
) (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus between the two ends
  input wire logic       chip_select_n,
  input wire logic       cmd_data_select,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] host_db,
  input wire logic       host_db_oe,
  input wire logic [7:0] dev_db,
  input wire logic       dev_db_oe
);
  // ****************************************************************
  // strobe width counters
  // ****************************************************************
  logic [7:0] wr_low_ff;
  logic [7:0] rd_low_ff;
  always_ff @(posedge aclk)
    wr_low_ff <= (!aresetn || wr_n) ? 8'h00 : wr_low_ff + 8'h01;
  always_ff @(posedge aclk)
    rd_low_ff <= (!aresetn || rd_n) ? 8'h00 : rd_low_ff + 8'h01;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rd_go;
    !chip_select_n && $fell(rd_n);
  endsequence
  sequence wr_end;
    $rose(wr_n) ##0 !chip_select_n;
  endsequence
  AST_WR_SELECTED: assert property (!wr_n |-> !chip_select_n)
    else $error("write without select");
  AST_RD_SELECTED: assert property (!rd_n |-> !chip_select_n)
    else $error("read without select");
  AST_DRIVE_SELECTED: assert property (dev_db_oe |-> !$past(chip_select_n))
    else $error("device drives unselected");
  AST_NO_CLASH: assert property (!(host_db_oe && dev_db_oe))
    else $error("bus clash");
  AST_RD_ANSWER: assert property (rd_go |-> ##[1:3] dev_db_oe)
    else $error("read not answered");
  AST_RD_HELD: assert property (dev_db_oe && $past(dev_db_oe) |-> $stable(dev_db))
    else $error("read byte changed");
  AST_WR_HELD: assert property (!wr_n |-> host_db_oe && $stable(host_db) && $stable(cmd_data_select))
    else $error("write byte moved in strobe");
  AST_WR_WIDTH: assert property (wr_end |-> wr_low_ff == T_WRW)
    else $error("write strobe width wrong");
  AST_RD_WIDTH: assert property ($rose(rd_n) |-> rd_low_ff == T_RDW)
    else $error("read strobe width wrong");
endmodule : lcdcp_wire_asserts

// ---- dv/tb_top.sv ----
// self-checking bench: axi host end driving the device end
`timescale 1ns/100ps
`include "lcdcp_cfg.svh"
module tb_top;
  import lcdcp_pkg::*;
  typedef struct packed {
    logic [10:0] cmd;
    logic [3:0]  col;
    logic        rf;
    logic [1:0]  rsp;
  } lcdcp_row_s;
  logic        aclk = 1'b0, aresetn = 1'b0, rf;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, col, col2;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  lcdcp_word_t s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_val;
  logic [10:0] scan_addr = 11'h000;
  lcdcp_byte_t scan_data;
  logic [6:0]  row;
  int          error_cnt = 0, n_tests = 0;
  // op 1 refused; ext writes leave the column alone
  lcdcp_row_s  rows [7] = '{'{11'h105, 4'h5, 1'b0, 2'h0}, '{11'h191, 4'h5, 1'b1, 2'h0},
    '{11'h10F, 4'hF, 1'b1, 2'h0}, '{11'h113, 4'hF, 1'b1, `LCDCP_RESP_SLVERR},
    '{11'h580, 4'hF, 1'b1, 2'h0}, '{11'h190, 4'hF, 1'b0, 2'h0}, '{11'h100, 4'h0, 1'b0, 2'h0}};
  always #10 aclk = ~aclk;
  lcdcp_if lcd ();
  lcdcp_if lcd2 ();
  lcdcp_host #(.T_AS(1), .T_WRW(2), .T_RDW(4), .T_DH(1), .T_CYC(8)) lcdcp_host_inst (
    .lcd(lcd.host), .*);
  lcdcp_device lcdcp_device_inst (.aclk(aclk), .aresetn(aresetn), .lcd(lcd.dev),
    .scan_addr(scan_addr), .scan_data(scan_data), .column_address_bits(col),
    .row_address_bits(row), .col_reversed(rf));
  // bench-driven second device for rule-breaking transfers
  lcdcp_device lcdcp_device_inst2 (.aclk(aclk), .aresetn(aresetn), .lcd(lcd2.dev),
    .scan_addr(scan_addr), .scan_data(), .column_address_bits(col2), .row_address_bits(),
    .col_reversed());
  lcdcp_wire_asserts lcdcp_wire_asserts_inst (.aclk(aclk),
    .aresetn(aresetn), .chip_select_n(lcd.chip_select_n), .cmd_data_select(lcd.cmd_data_select),
    .wr_n(lcd.wr_n), .rd_n(lcd.rd_n), .host_db(lcd.host_db), .host_db_oe(lcd.host_db_oe),
    .dev_db(lcd.dev_db), .dev_db_oe(lcd.dev_db_oe));
  // ****************************************************************
  // bus tasks and checks
  // ****************************************************************
  task automatic chk(input string n, input lcdcp_word_t e, input lcdcp_word_t g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input lcdcp_word_t d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output lcdcp_word_t d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic cmd(input logic [10:0] c);
    axi_wr(`LCDCP_OFS_CMD, 32'(c), rsp);
  endtask : cmd
  task automatic wait_idle();
    do axi_rd(`LCDCP_OFS_STATUS, rd_val, rsp); while (rd_val[0] !== 1'b0);
  endtask : wait_idle
  task automatic scan(input logic [10:0] a, input lcdcp_byte_t e);
    @(posedge aclk);
    scan_addr <= a;
    repeat (2) @(posedge aclk);
    chk("scan_data", 32'(e), 32'(scan_data));
  endtask : scan
  task automatic pulse2();
    @(posedge aclk);
    lcd2.wr_n <= 1'b0;
    repeat (3) @(posedge aclk);
    lcd2.wr_n <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : pulse2
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    lcd2.chip_select_n = 1'b1;
    lcd2.cmd_data_select = 1'b1;
    lcd2.ext_bank_select = 1'b0;
    lcd2.wr_n = 1'b1;
    lcd2.rd_n = 1'b1;
    lcd2.host_db = 8'h07;
    lcd2.host_db_oe = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(`LCDCP_OFS_CMD, 32'(rows[i].cmd), rsp);
      chk("bresp", 32'(rows[i].rsp), 32'(rsp));
      wait_idle();
      chk("column", 32'(rows[i].col), 32'(col));
      chk("reversal", 32'(rows[i].rf), 32'(rf));
    end
    $display("test command table done");
    cmd(11'h109);
    cmd(11'h309);
    wait_idle();
    axi_rd(`LCDCP_OFS_RDATA, rd_val, rsp);
    chk("column readback", 32'h0000_0009, rd_val);
    cmd(11'h122);
    cmd(11'h131);
    cmd(11'h103);
    // pushes outrun the bus and fill the fifo
    for (int i = 0; i < 8; i++) cmd(11'(8'hA0 + i));
    wait_idle();
    chk("row", 32'h0000_0012, 32'(row));
    scan({7'h12, 4'h3}, 8'hA7);
    cmd(11'h191);
    cmd(11'h05A);
    wait_idle();
    scan({7'h12, 4'hC}, 8'h5A);
    scan({7'h12, 4'h3}, 8'hA7);
    cmd(11'h200);
    wait_idle();
    axi_rd(`LCDCP_OFS_RDATA, rd_val, rsp);
    chk("ram readback", 32'h0000_005A, rd_val);
    $display("test ram path done");
    axi_wr(4'hC, 32'h0000_0000, rsp);
    chk("unmapped bresp", 32'(`LCDCP_RESP_SLVERR), 32'(rsp));
    axi_rd(4'hC, rd_val, rsp);
    chk("unmapped rresp", 32'(`LCDCP_RESP_SLVERR), 32'(rsp));
    $display("test unmapped done");
    pulse2();
    chk("unselected column", 32'h0000_0000, 32'(col2));
    lcd2.chip_select_n <= 1'b0;
    pulse2();
    chk("selected column", 32'h0000_0007, 32'(col2));
    $display("test chip select done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("column after reset", 32'h0000_0000, 32'(col));
    chk("reversal after reset", 32'h0000_0000, 32'(rf));
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_top
